// >>> design/iah_map.vh
// constants for the interlocked access handshake block
// assumes inclusion by bare name from design files
`ifndef IAH_MAP_VH
`define IAH_MAP_VH
// operation codes on op_code
`define IAH_OP_W 3
`define IAH_OP_PLAIN_LOAD 3'h0
`define IAH_OP_PLAIN_STORE 3'h1
`define IAH_OP_INT_LOAD 3'h2
`define IAH_OP_FLOAT_LOAD 3'h3
`define IAH_OP_INT_STORE 3'h4
`define IAH_OP_FLOAT_STORE 3'h5
`define IAH_OP_SIGNAL 3'h6
// target classes on op_target
`define IAH_TGT_W 2
`define IAH_TGT_ONCHIP_MEM 2'h0
`define IAH_TGT_PERIPH 2'h1
`define IAH_TGT_PRIMARY 2'h2
`define IAH_TGT_EXPANSION 2'h3
// log depth of the operation trace memory
`define IAH_LOG_AW 3
`define IAH_LOG_DW 4
// reset levels (active low request released)
`define IAH_REQ_RESET 1'b1
`endif

// >>> design/iah_log_mem.v
// small register file recording finished operations
// assumes one clock; read data registered
`timescale 1ns/1ps
`default_nettype none
`include "iah_map.vh"
module iah_log_mem (
   input wire clk_sys,
   input wire reset,
   input wire clk_en,
   input wire wr_en,
   input wire [`IAH_LOG_AW-1:0] wr_addr,
   input wire [`IAH_LOG_DW-1:0] wr_data,
   input wire [`IAH_LOG_AW-1:0] rd_addr,
   output reg [`IAH_LOG_DW-1:0] rd_data_r
);
   reg [`IAH_LOG_DW-1:0] mem [0:(1<<`IAH_LOG_AW)-1];
   always @(posedge clk_sys) begin
      if (clk_en && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_data_r <= 4'h0;
      end else if (clk_en) begin
         rd_data_r <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

// >>> design/iah_core.v
// interlocked access handshake sequencer
// assumes op_start is a one-cycle pulse from the core on clk_sys,
// ack pin and ready inputs come from outside and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "iah_map.vh"
module iah_core (
   input wire clk_sys,
   input wire reset,
   input wire clk_en,
   input wire op_start,
   input wire [`IAH_OP_W-1:0] op_code,
   input wire [`IAH_TGT_W-1:0] op_target,
   input wire op_src_is_mem,
   input wire irq_pending,
   input wire interlock_ack_in,
   input wire ready_in_n,
   input wire [`IAH_LOG_AW-1:0] log_rd_addr,
   output reg interlock_request_out,
   output reg interlock_request_oe,
   output reg bus_cycle_r,
   output reg bus_write_r,
   output reg op_busy_r,
   output reg op_done_r,
   output reg op_abandon_r,
   output reg op_illegal_r,
   output reg irq_take_r,
   output wire [`IAH_LOG_DW-1:0] log_rd_data
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_RD = 5'b00010;
   localparam ST_RD_ACK = 5'b00100;
   localparam ST_WR = 5'b01000;
   localparam ST_SIG = 5'b10000;

   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [2:0] ack_sync_r;
   reg [2:0] rdy_sync_r;
   reg ack_low_r;
   reg rdy_low_r;
   reg req_nxt;
   reg cyc_nxt;
   reg wr_nxt;
   reg busy_nxt;
   reg done_nxt;
   reg abandon_nxt;
   reg illegal_nxt;
   reg take_nxt;
   reg [`IAH_LOG_AW-1:0] log_ptr_r;
   reg log_we;
   reg [`IAH_LOG_DW-1:0] log_wd;
   reg [`IAH_OP_W-1:0] op_code_r;
   wire is_load;
   wire is_store;
   wire is_plain;

   // a target reached over a bus cycle or a peripheral
   function ext_target;
      input [`IAH_TGT_W-1:0] tgt;
      begin
         ext_target = (tgt != `IAH_TGT_ONCHIP_MEM);
      end
   endfunction

   // a target that needs a strobe on one of the external buses
   function bus_target;
      input [`IAH_TGT_W-1:0] tgt;
      begin
         bus_target = ext_target(tgt) && (tgt != `IAH_TGT_PERIPH);
      end
   endfunction

   // interlocked loads of either number format
   function op_load;
      input [`IAH_OP_W-1:0] code;
      begin
         op_load = (code == `IAH_OP_INT_LOAD) ||
            (code == `IAH_OP_FLOAT_LOAD);
      end
   endfunction

   // interlocked stores of either number format
   function op_store;
      input [`IAH_OP_W-1:0] code;
      begin
         op_store = (code == `IAH_OP_INT_STORE) ||
            (code == `IAH_OP_FLOAT_STORE);
      end
   endfunction

   // ordinary accesses that never touch the request pin
   function op_plain;
      input [`IAH_OP_W-1:0] code;
      begin
         op_plain = (code == `IAH_OP_PLAIN_LOAD) ||
            (code == `IAH_OP_PLAIN_STORE);
      end
   endfunction

   // filtered pin levels: change only once stages two and three agree,
   // so a level caught near its edge never reaches the sequencer
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ack_sync_r <= 3'h7;
         ack_low_r <= 1'b0;
      end else if (clk_en) begin
         ack_sync_r <= {ack_sync_r[1:0], interlock_ack_in};
         if (ack_sync_r[1] == ack_sync_r[2]) begin
            ack_low_r <= ~ack_sync_r[2];
         end
      end
   end

   // combined ready passes the same filter
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdy_sync_r <= 3'h7;
         rdy_low_r <= 1'b0;
      end else if (clk_en) begin
         rdy_sync_r <= {rdy_sync_r[1:0], ready_in_n};
         if (rdy_sync_r[1] == rdy_sync_r[2]) begin
            rdy_low_r <= ~rdy_sync_r[2];
         end
      end
   end

   assign is_load = op_load(op_code);
   assign is_store = op_store(op_code);
   assign is_plain = op_plain(op_code);

   always @* begin
      state_nxt = state_r;
      req_nxt = interlock_request_out;
      cyc_nxt = bus_cycle_r;
      wr_nxt = bus_write_r;
      busy_nxt = op_busy_r;
      done_nxt = 1'b0;
      abandon_nxt = 1'b0;
      illegal_nxt = 1'b0;
      take_nxt = 1'b0;
      log_we = 1'b0;
      log_wd = {1'b0, op_code};
      case (state_r)
         ST_IDLE: begin
            if (op_start) begin
               busy_nxt = 1'b1;
               if (op_code == `IAH_OP_SIGNAL) begin
                  req_nxt = 1'b0;
                  state_nxt = ST_SIG;
               end else if (is_load && !op_src_is_mem) begin
                  illegal_nxt = 1'b1;
                  busy_nxt = 1'b0;
               end else if (is_load || is_store || is_plain) begin
                  wr_nxt = is_store || (op_code == `IAH_OP_PLAIN_STORE);
                  if (ext_target(op_target)) begin
                     cyc_nxt = bus_target(op_target);
                     if (is_load) begin
                        req_nxt = 1'b0;
                        state_nxt = ST_RD_ACK;
                     end else begin
                        if (is_store) begin
                           req_nxt = 1'b1;
                        end
                        state_nxt = ST_WR;
                     end
                  end else begin
                     // on-chip memory: internal access, request untouched
                     done_nxt = 1'b1;
                     busy_nxt = 1'b0;
                  end
               end else begin
                  illegal_nxt = 1'b1;
                  busy_nxt = 1'b0;
               end
            end
         end
         ST_RD_ACK: begin
            if (ack_low_r && rdy_low_r) begin
               cyc_nxt = 1'b0;
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end else if (rdy_low_r && irq_pending) begin
               cyc_nxt = 1'b0;
               busy_nxt = 1'b0;
               abandon_nxt = 1'b1;
               take_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_WR: begin
            if (rdy_low_r) begin
               cyc_nxt = 1'b0;
               wr_nxt = 1'b0;
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_SIG: begin
            if (ack_low_r) begin
               req_nxt = 1'b1;
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end else if (irq_pending) begin
               busy_nxt = 1'b0;
               abandon_nxt = 1'b1;
               take_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cyc_nxt = 1'b0;
            busy_nxt = 1'b0;
         end
      endcase
      if (done_nxt || abandon_nxt) begin
         log_we = 1'b1;
         log_wd = {abandon_nxt, (state_r == ST_IDLE) ? op_code : op_code_r};
      end
   end

   // state and the code of the operation in flight
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         op_code_r <= 3'h0;
         log_ptr_r <= 3'h0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE && op_start) begin
            op_code_r <= op_code;
         end
         if (log_we) begin
            log_ptr_r <= log_ptr_r + 3'h1;
         end
      end
   end

   // pin and bus levels hold until the sequencer changes them
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         interlock_request_out <= `IAH_REQ_RESET;
         interlock_request_oe <= 1'b0;
         bus_cycle_r <= 1'b0;
         bus_write_r <= 1'b0;
         op_busy_r <= 1'b0;
      end else if (clk_en) begin
         interlock_request_out <= req_nxt;
         interlock_request_oe <= 1'b1;
         bus_cycle_r <= cyc_nxt;
         bus_write_r <= wr_nxt;
         op_busy_r <= busy_nxt;
      end
   end

   // one-cycle status pulses towards the core
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         op_done_r <= 1'b0;
         op_abandon_r <= 1'b0;
         op_illegal_r <= 1'b0;
         irq_take_r <= 1'b0;
      end else if (clk_en) begin
         op_done_r <= done_nxt;
         op_abandon_r <= abandon_nxt;
         op_illegal_r <= illegal_nxt;
         irq_take_r <= take_nxt;
      end
   end

   iah_log_mem u_log (
      .clk_sys(clk_sys),
      .reset(reset),
      .clk_en(clk_en),
      .wr_en(log_we),
      .wr_addr(log_ptr_r),
      .wr_data(log_wd),
      .rd_addr(log_rd_addr),
      .rd_data_r(log_rd_data)
   );
endmodule
`default_nettype wire

// >>> verification/iah_core_props.sv
// assertions on the ports of the interlocked access sequencer
// assumes a bind onto iah_core and a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "iah_map.vh"
module iah_core_chk (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic op_start,
   input wire logic [`IAH_OP_W-1:0] op_code,
   input wire logic [`IAH_TGT_W-1:0] op_target,
   input wire logic op_src_is_mem,
   input wire logic interlock_ack_in,
   input wire logic ready_in_n,
   input wire logic interlock_request_out,
   input wire logic interlock_request_oe,
   input wire logic bus_cycle_r,
   input wire logic bus_write_r,
   input wire logic op_busy_r,
   input wire logic op_done_r,
   input wire logic op_abandon_r,
   input wire logic op_illegal_r,
   input wire logic irq_take_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire take = op_start && !op_busy_r && clk_en;
   wire ext = op_target != `IAH_TGT_ONCHIP_MEM;
   pin_enable_a: assert property (!$past(reset) |-> interlock_request_oe)
      else $error("request pin not driven");
   load_lowers_a: assert property (take && ext && op_src_is_mem &&
      op_code == `IAH_OP_INT_LOAD |=> ##1 !interlock_request_out)
      else $error("load left request high");
   store_raises_a: assert property (take && ext && op_code ==
      `IAH_OP_INT_STORE |=> ##1 interlock_request_out)
      else $error("store left request low");
   onchip_quiet_a: assert property (take && !ext && op_code !=
      `IAH_OP_SIGNAL |=> $stable(interlock_request_out) && !bus_cycle_r)
      else $error("on-chip access touched the pins");
   load_holds_a: assert property ($fell(bus_cycle_r) &&
      !$past(bus_write_r) && !$past(interlock_request_out)
      |-> !interlock_request_out) else $error("request released by load");
   ready_wait_a: assert property (
      (bus_cycle_r && ready_in_n)[*5] |=> !op_done_r)
      else $error("bus cycle ended without ready");
   ack_wait_a: assert property ((bus_cycle_r && !bus_write_r &&
      !interlock_request_out && interlock_ack_in)[*5] |=> !op_done_r)
      else $error("load ended without acknowledge");
   store_no_abandon_a: assert property (
      op_abandon_r |-> !$past(bus_write_r)) else $error("store abandoned");
   abandon_take_a: assert property (
      op_abandon_r |-> irq_take_r && !op_done_r)
      else $error("abandon without interrupt take");
   bad_source_a: assert property (take && !op_src_is_mem &&
      op_code == `IAH_OP_FLOAT_LOAD |-> ##[1:2] op_illegal_r)
      else $error("register source not refused");
endmodule
bind iah_core iah_core_chk chk (.*);
`default_nettype wire

// >>> verification/iah_arbiter_model.sv
// arbiter and ready source standing on the far side of the pins
// assumes one clock; request, acknowledge and ready are active low
`timescale 1ns/1ps
`default_nettype none
module iah_arbiter_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic req_n,
   input wire logic busy,
   input wire logic ack_block,
   input wire logic [2:0] wait_cyc,
   output logic ack_n,
   output logic rdy_n
);
   logic [3:0] cnt_r;
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cnt_r <= 4'h0;
         ack_n <= 1'b1;
         rdy_n <= 1'b1;
      end else begin
         // grant held until the request is released or ack_block is raised
         ack_n <= req_n | ack_block;
         cnt_r <= busy ? cnt_r + 4'h1 : 4'h0;
         rdy_n <= !(busy && cnt_r >= {1'b0, wait_cyc});
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb_interlocked_access_handshake.sv
// self-checking bench for the interlocked access sequencer
// assumes the arbiter model on the pins and a 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "iah_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_interlocked_access_handshake;
   logic clk_sys, reset, op_start, src, irq, blk, req_m;
   logic [2:0] code, wcyc, laddr, c_r;
   logic [1:0] tgt;
   logic [3:0] e;
   logic [3:0] expq[$];
   logic [31:0] rs = 32'h0000_1680;
   int error_cnt = 0;
   int total_checks = 0;
   wire ack_n, rdy_n, req, oe, busy, done, ab, ill;
   wire [3:0] got = {ill, ab, done, req};
   wire [3:0] lgd;
   logic hung = 1'b0;
   logic [3:0] lg [8];
   int lp = 0;
   iah_core dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1),
      .op_start(op_start), .op_code(code), .op_target(tgt),
      .op_src_is_mem(src), .irq_pending(irq), .interlock_ack_in(ack_n),
      .ready_in_n(rdy_n), .log_rd_addr(laddr), .interlock_request_out(req),
      .interlock_request_oe(oe), .bus_cycle_r(), .bus_write_r(),
      .op_busy_r(busy), .op_done_r(done), .op_abandon_r(ab),
      .op_illegal_r(ill), .irq_take_r(), .log_rd_data(lgd));
   iah_arbiter_model arb (.clk_sys(clk_sys), .reset(reset), .req_n(req),
      .busy(busy), .ack_block(blk), .wait_cyc(wcyc), .ack_n(ack_n),
      .rdy_n(rdy_n));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic summarize();
      if (expq.size() != 0)
         error_cnt++;
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic run_op(input logic [2:0] c, input logic [1:0] t,
      input logic s, input logic b);
      logic l, st, g, ilg, abd;
      int n;
      if (hung)
         return;
      l = c inside {`IAH_OP_INT_LOAD, `IAH_OP_FLOAT_LOAD};
      st = c inside {`IAH_OP_INT_STORE, `IAH_OP_FLOAT_STORE};
      g = c == `IAH_OP_SIGNAL;
      ilg = c == 3'h7 || l && !s;
      abd = !ilg && b && (g || l && t != `IAH_TGT_ONCHIP_MEM);
      if (!ilg && (g || (l || st) && t != `IAH_TGT_ONCHIP_MEM))
         req_m = st || g && !abd;
      expq.push_back({ilg, abd, !ilg && !abd, req_m});
      // a stale grant must clear the pin filter before the op is taken
      {blk, irq} = {b, b};
      repeat (6) @(posedge clk_sys);
      #1;
      if (lp > laddr)
         `CHK(lgd, lg[laddr])
      if (!ilg) begin
         lg[lp % 8] = {abd, c};
         lp++;
      end
      rs = xs(rs);
      {wcyc, laddr} = rs[5:0];
      {code, tgt, src, op_start} = {c, t, s, 1'b1};
      @(posedge clk_sys);
      #1;
      op_start = 1'b0;
      for (n = 0; n < 300 && !(done | ab | ill); n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (n == 300) begin
         error_cnt++;
         hung = 1'b1;
      end
   endtask
   always @(negedge clk_sys) begin
      if (done | ab | ill) begin
         e = expq.size() ? expq.pop_front() : 4'hf;
         `CHK(got, e)
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      {op_start, code, tgt, src, irq, blk, wcyc, laddr} = '0;
      {reset, req_m} = 2'h3;
      repeat (2) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK(oe, 1'b1)
      `CHK(req, 1'b1)
      run_op(3'h2, 2'h2, 1'b1, 1'b0);
      run_op(3'h4, 2'h0, 1'b1, 1'b0);
      run_op(3'h5, 2'h3, 1'b1, 1'b1);
      run_op(3'h3, 2'h1, 1'b1, 1'b0);
      run_op(3'h4, 2'h1, 1'b1, 1'b0);
      run_op(3'h2, 2'h0, 1'b1, 1'b0);
      run_op(3'h6, 2'h2, 1'b1, 1'b0);
      run_op(3'h6, 2'h2, 1'b1, 1'b1);
      run_op(3'h2, 2'h3, 1'b1, 1'b1);
      run_op(3'h3, 2'h2, 1'b0, 1'b0);
      run_op(3'h7, 2'h2, 1'b1, 1'b0);
      repeat (24) begin
         rs = xs(rs);
         c_r = rs[10:8] % 3'h7;
         run_op(c_r, rs[12:11], 1'b1, rs[13] && c_r > 3'h1);
      end
      repeat (2) @(posedge clk_sys);
      summarize();
   end
endmodule
`default_nettype wire
